//--- rtl/bifa_pkg.sv
/*
 * shared constants and types of the built-in i/o function allocator:
 * register offsets, field positions, reset values, pin positions, timing.
 * assumes a 50 MHz system clock.
 */
package bifa_pkg;

    // ========================================
    // register map (byte offsets)
    localparam logic [4:0] INCFG_OFS = 5'h00;
    localparam logic [4:0] HSCCFG_OFS = 5'h04;
    localparam logic [4:0] ORGCFG_OFS = 5'h08;
    localparam logic [4:0] OUTLVL_OFS = 5'h0C;
    localparam logic [4:0] PLSCTL_OFS = 5'h10;
    localparam logic [4:0] INSTATE_OFS = 5'h14;
    localparam logic [4:0] IRQST_OFS = 5'h18;
    localparam logic [4:0] IRQMSK_OFS = 5'h1C;

    // ========================================
    // field positions and reset values
    localparam int FILT_SEL_POS = 0;
    localparam int INT_EN_POS = 8;
    localparam int QUICK_EN_POS = 16;
    localparam int PLS_DIR_POS = 4;
    localparam logic [2:0] FILT_SEL_RST = 3'h5;
    localparam logic [31:0] INCFG_RST = 32'h00000005;

    // ========================================
    // timing: filter steps are multiples of half a millisecond
    localparam int CLK_PERIOD_NS = 20;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYC = HALF_MS_NS / CLK_PERIOD_NS;

    // ========================================
    // pin positions inside the 24-bit input vector (word 1 starts at 12)
    localparam int N_IN = 24;
    localparam int N_HSC = 4;
    localparam int N_OUT = 8;
    localparam int W1_BASE = 12;

    typedef enum logic [1:0] {
        HSC_DIFF = 2'b00,
        HSC_PDIR = 2'b01,
        HSC_UPDN = 2'b10,
        HSC_INC = 2'b11
    } bifa_hsc_mode_t;

    typedef struct packed {
        logic en;
        logic zrst;
        bifa_hsc_mode_t mode;
    } bifa_hsc_cfg_t;

    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
    } bifa_pulse_src_t;

    // phase pins of each counter
    function automatic int hsc_a_pin(input int k);
        case (k)
            0: return 8;
            1: return 6;
            2: return 4;
            default: return 10;
        endcase
    endfunction

    function automatic int hsc_z_pin(input int k);
        return (k == 3) ? W1_BASE : 3 - k;
    endfunction

    // interrupt/quick input i to pin: 0..3 on word 0, 4..7 on word 1
    function automatic int irq_pin(input int i);
        return (i < 4) ? i : W1_BASE + i - 4;
    endfunction

endpackage

//--- rtl/bifa_in_filter.sv
/*
 * on/off response filter for one input bit: the output follows the input
 * only after it held a new level for more than the given cycle count.
 * assumes the input is synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
module bifa_in_filter (
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic RAW_IN,
    input wire logic [21:0] LIMIT_IN,
    output logic FILT_OUT
);
    logic [21:0] cnt_reg;

    // ========================================
    // stability counter
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            cnt_reg <= 22'h000000;
            FILT_OUT <= 1'b0;
        end else if (RAW_IN == FILT_OUT) begin
            cnt_reg <= 22'h000000;
        end else if (cnt_reg >= LIMIT_IN) begin
            FILT_OUT <= RAW_IN;
            cnt_reg <= 22'h000000;
        end else begin
            cnt_reg <= cnt_reg + 22'h000001;
        end
    end
endmodule
`default_nettype wire

//--- rtl/bifa_top.sv
/*
 * built-in i/o function allocator: routes the 24 input bits to plain,
 * counter, interrupt, quick-response and origin functions and the 8 output
 * bits to plain levels or pulse trains, configured over avalon-mm.
 * assumes pins and pulse engine signals are synchronous to REF_CLK_IN.
 */
`timescale 1ns/100ps
`default_nettype none
module bifa_top #(
    parameter int HALF_MS_CYCLES = bifa_pkg::HALF_MS_CYC
) (
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [4:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [23:0] IN_PINS_IN,
    input wire bifa_pkg::bifa_pulse_src_t PULSE_SRC_IN,
    output logic [7:0] OUT_PINS_OUT,
    output logic [3:0] HSC_A_OUT,
    output logic [3:0] HSC_B_OUT,
    output logic [3:0] HSC_Z_OUT,
    output logic [3:0] HSC_RST_OUT,
    output logic [7:0] ORIGIN_OUT,
    output logic [7:0] QUICK_OUT,
    output logic IRQ_OUT
);
    import bifa_pkg::*;

    logic [31:0] incfg_reg;
    logic [15:0] hsccfg_reg;
    logic [3:0] orgcfg_reg;
    logic [7:0] outlvl_reg;
    logic [7:0] plsctl_reg;
    logic [15:0] irqst_reg;
    logic [15:0] irqmsk_reg;
    logic [23:0] pins_prev_reg;
    logic [23:0] filt;
    logic [23:0] org_claim;
    logic [23:0] hsc_claim;
    logic [15:0] irq_set;
    logic [7:0] out_next;
    logic [21:0] filt_limit;
    logic wr_acc;
    logic acc_start;
    logic [31:0] rd_next;

    // byte-lane merge used for every writable register
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic bifa_hsc_cfg_t hsc_cfg(input logic [15:0] c,
                                              input int k);
        return bifa_hsc_cfg_t'(c[4*k +: 4]);
    endfunction

    // ========================================
    // avalon slave: one wait cycle, then the access completes
    assign wr_acc = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
    assign acc_start = (AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT; // request in its wait cycle

    // waitrequest drops for one cycle per request
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
        end else begin
            AVS_WAITREQUEST_OUT <= ~acc_start;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_next = 32'h00000000;
        case (AVS_ADDRESS_IN)
            INCFG_OFS: rd_next = incfg_reg;
            HSCCFG_OFS: rd_next = {16'h0000, hsccfg_reg};
            ORGCFG_OFS: rd_next = {28'h0000000, orgcfg_reg};
            OUTLVL_OFS: rd_next = {24'h000000, outlvl_reg};
            PLSCTL_OFS: rd_next = {24'h000000, plsctl_reg};
            INSTATE_OFS: rd_next = {8'h00, filt & ~(org_claim | hsc_claim)};
            IRQST_OFS: rd_next = {16'h0000, irqst_reg};
            IRQMSK_OFS: rd_next = {16'h0000, irqmsk_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    // read data register, loaded as the wait cycle ends
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            AVS_READDATA_OUT <= 32'h00000000;
        end else if (acc_start) begin
            AVS_READDATA_OUT <= rd_next;
        end
    end

    // ========================================
    // configuration registers
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            incfg_reg <= INCFG_RST;
            hsccfg_reg <= 16'h0000;
            orgcfg_reg <= 4'h0;
            outlvl_reg <= 8'h00;
            plsctl_reg <= 8'h00;
            irqmsk_reg <= 16'h0000;
        end else if (wr_acc) begin
            case (AVS_ADDRESS_IN)
                INCFG_OFS: incfg_reg <= be_merge(incfg_reg, AVS_WRITEDATA_IN,
                                                 AVS_BYTEENABLE_IN) & 32'h00FFFF07;
                HSCCFG_OFS: hsccfg_reg <= 16'(be_merge({16'h0000, hsccfg_reg},
                                  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
                ORGCFG_OFS: orgcfg_reg <= 4'(be_merge({28'h0000000, orgcfg_reg},
                                  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
                OUTLVL_OFS: outlvl_reg <= 8'(be_merge({24'h000000, outlvl_reg},
                                  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
                PLSCTL_OFS: plsctl_reg <= 8'(be_merge({24'h000000, plsctl_reg},
                                  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
                IRQMSK_OFS: irqmsk_reg <= 16'(be_merge({16'h0000, irqmsk_reg},
                                  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
                default: ;
            endcase
        end
    end

    // ========================================
    // response filters on every input bit
    always_comb begin
        filt_limit = 22'h000000;
        if (incfg_reg[FILT_SEL_POS +: 3] != 3'h0) begin
            filt_limit = 22'((32'h1 << (incfg_reg[FILT_SEL_POS +: 3] - 3'h1))
                             * HALF_MS_CYCLES);
        end
    end

    for (genvar g = 0; g < N_IN; g++) begin : g_filt
        bifa_in_filter u_filt (
            .REF_CLK_IN(REF_CLK_IN),
            .SYS_RST_IN(SYS_RST_IN),
            .RAW_IN(IN_PINS_IN[g]),
            .LIMIT_IN(filt_limit),
            .FILT_OUT(filt[g])
        );
    end

    // ========================================
    // pin ownership: origin search first, then counters
    always_comb begin
        org_claim = 24'h000000;
        hsc_claim = 24'h000000;
        for (int k = 0; k < 4; k++) begin
            if (orgcfg_reg[k]) begin
                org_claim[2*k + ((k >= 2) ? 8 : 0)] = 1'b1;
                org_claim[2*k + 1 + ((k >= 2) ? 8 : 0)] = 1'b1;
            end
        end
        for (int k = 0; k < N_HSC; k++) begin
            if (hsc_cfg(hsccfg_reg, k).en) begin
                hsc_claim[hsc_a_pin(k)] = 1'b1;
                hsc_claim[hsc_z_pin(k)] = 1'b1;
                if (hsc_cfg(hsccfg_reg, k).mode != HSC_INC) begin
                    hsc_claim[hsc_a_pin(k) + 1] = 1'b1;
                end
            end
        end
        hsc_claim = hsc_claim & ~org_claim;
    end

    // ========================================
    // counter phase routing
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            HSC_A_OUT <= 4'h0;
            HSC_B_OUT <= 4'h0;
            HSC_Z_OUT <= 4'h0;
            HSC_RST_OUT <= 4'h0;
        end else begin
            for (int k = 0; k < N_HSC; k++) begin
                HSC_A_OUT[k] <= IN_PINS_IN[hsc_a_pin(k)] & hsc_claim[hsc_a_pin(k)];
                HSC_B_OUT[k] <= IN_PINS_IN[hsc_a_pin(k) + 1]
                                & hsc_claim[hsc_a_pin(k) + 1];
                HSC_Z_OUT[k] <= IN_PINS_IN[hsc_z_pin(k)] & hsc_claim[hsc_z_pin(k)]
                                & ~hsc_cfg(hsccfg_reg, k).zrst;
                HSC_RST_OUT[k] <= IN_PINS_IN[hsc_z_pin(k)] & hsc_claim[hsc_z_pin(k)]
                                  & hsc_cfg(hsccfg_reg, k).zrst;
            end
        end
    end

    // origin and proximity inputs of each pulse output
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            ORIGIN_OUT <= 8'h00;
        end else begin
            ORIGIN_OUT <= {IN_PINS_IN[15:12] & org_claim[15:12],
                           IN_PINS_IN[3:0] & org_claim[3:0]};
        end
    end

    // ========================================
    // interrupt and quick-response events on rising edges
    always_comb begin
        irq_set = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (~(org_claim[irq_pin(i)] | hsc_claim[irq_pin(i)])
                & IN_PINS_IN[irq_pin(i)] & ~pins_prev_reg[irq_pin(i)]) begin
                if (incfg_reg[INT_EN_POS + i]) begin
                    irq_set[i] = 1'b1;
                end else if (incfg_reg[QUICK_EN_POS + i]) begin
                    irq_set[8 + i] = 1'b1;
                end
            end
        end
    end

    // previous pin levels for edge detection
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            pins_prev_reg <= 24'h000000;
        end else begin
            pins_prev_reg <= IN_PINS_IN;
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            irqst_reg <= 16'h0000;
        end else if (wr_acc && AVS_ADDRESS_IN == IRQST_OFS) begin
            irqst_reg <= (irqst_reg & ~16'(be_merge(32'h00000000, AVS_WRITEDATA_IN,
                          AVS_BYTEENABLE_IN))) | irq_set;
        end else begin
            irqst_reg <= irqst_reg | irq_set;
        end
    end

    // interrupt level and latched quick-response bits
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            IRQ_OUT <= 1'b0;
            QUICK_OUT <= 8'h00;
        end else begin
            IRQ_OUT <= |(irqst_reg & irqmsk_reg);
            QUICK_OUT <= irqst_reg[15:8];
        end
    end

    // ========================================
    // output bits: plain level unless a pulse output is running
    always_comb begin
        out_next = outlvl_reg;
        for (int k = 0; k < 4; k++) begin
            if (plsctl_reg[k]) begin
                if (!plsctl_reg[PLS_DIR_POS + k]) begin
                    out_next[2*k] = PULSE_SRC_IN.a[k];
                    out_next[2*k + 1] = PULSE_SRC_IN.b[k];
                end else if (k < 2) begin
                    out_next[k] = PULSE_SRC_IN.a[k];
                    out_next[k + 2] = PULSE_SRC_IN.b[k];
                end else begin
                    out_next[2*k] = PULSE_SRC_IN.a[k];
                    out_next[2*k + 1] = PULSE_SRC_IN.b[k];
                end
            end
        end
    end

    // registered output pins
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            OUT_PINS_OUT <= 8'h00;
        end else begin
            OUT_PINS_OUT <= out_next;
        end
    end
endmodule
`default_nettype wire

//--- testbench/bifa_checker.sv
/*
 * checker of the i/o function allocator: bus answer, counter pin routing,
 * origin priority and output routing, seen at the top module ports.
 * assumes full-word writes, so the shadow registers ignore byte lanes.
 */
`timescale 1ns/100ps
`default_nettype none
module bifa_checker (
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [4:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic [23:0] IN_PINS_IN,
    input wire bifa_pkg::bifa_pulse_src_t PULSE_SRC_IN,
    input wire logic [7:0] OUT_PINS_OUT,
    input wire logic [3:0] HSC_A_OUT,
    input wire logic [3:0] HSC_B_OUT,
    input wire logic [3:0] HSC_Z_OUT,
    input wire logic [3:0] HSC_RST_OUT,
    input wire logic [7:0] ORIGIN_OUT
);
    import bifa_pkg::*;
    localparam int APIN [4] = '{8, 6, 4, 10};
    localparam int ZPIN [4] = '{3, 2, 1, 12};
    logic [15:0] hsc_reg;
    logic [3:0] org_reg;
    logic [7:0] pls_reg;
    logic [7:0] lvl_reg;
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // ========================================
    // shadow of routing registers, taken at the edge a write completes
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            hsc_reg <= 16'h0000;
            org_reg <= 4'h0;
            pls_reg <= 8'h00;
            lvl_reg <= 8'h00;
        end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT) begin
            case (AVS_ADDRESS_IN)
                HSCCFG_OFS: hsc_reg <= AVS_WRITEDATA_IN[15:0];
                ORGCFG_OFS: org_reg <= AVS_WRITEDATA_IN[3:0];
                PLSCTL_OFS: pls_reg <= AVS_WRITEDATA_IN[7:0];
                OUTLVL_OFS: lvl_reg <= AVS_WRITEDATA_IN[7:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // bus: one wait cycle, then idle again
    sequence s_req;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_answer;
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endsequence
    a_bus_answer: assert property (s_req |=> s_answer)
        else $error("waitrequest answer not one cycle");
    a_bus_idle: assert property (!AVS_READ_IN && !AVS_WRITE_IN && AVS_WAITREQUEST_OUT
        |=> AVS_WAITREQUEST_OUT) else $error("waitrequest dropped without request");

    // ========================================
    // counter pins follow their fixed input bits one cycle late
    for (genvar k = 0; k < 4; k++) begin : g_cnt
        a_hsc_phase: assert property (
            hsc_reg[4*k+3] && hsc_reg[4*k+1:4*k] != 2'b11 |=> HSC_A_OUT[k] ==
            $past(IN_PINS_IN[APIN[k]]) && HSC_B_OUT[k] == $past(IN_PINS_IN[APIN[k]+1]))
            else $error("counter phase pin routed wrong");
        a_inc_free: assert property (
            hsc_reg[4*k+3] && hsc_reg[4*k+1:4*k] == 2'b11 |=> HSC_B_OUT[k] == 1'b0)
            else $error("increment mode kept phase b");
        a_z_pulse: assert property (
            hsc_reg[4*k+3:4*k+2] == 2'b10 && org_reg == 4'h0 |=>
            HSC_Z_OUT[k] == $past(IN_PINS_IN[ZPIN[k]]) && HSC_RST_OUT[k] == 1'b0)
            else $error("z pulse routed wrong");
        a_z_reset: assert property (
            hsc_reg[4*k+3:4*k+2] == 2'b11 && org_reg == 4'h0 |=>
            HSC_RST_OUT[k] == $past(IN_PINS_IN[ZPIN[k]]) && HSC_Z_OUT[k] == 1'b0)
            else $error("counter reset routed wrong");
    end

    // ========================================
    // origin priority and output routing
    a_org_first: assert property (org_reg[1] |=> HSC_Z_OUT[0] == 1'b0 &&
        ORIGIN_OUT[2] == $past(IN_PINS_IN[2])) else $error("origin lost its pin");
    a_pulse_route: assert property (pls_reg == 8'h01 |=>
        OUT_PINS_OUT[0] == $past(PULSE_SRC_IN.a[0]) &&
        OUT_PINS_OUT[1] == $past(PULSE_SRC_IN.b[0])) else $error("pulse not on outputs");
    a_plain_level: assert property (pls_reg == 8'h00 |=> OUT_PINS_OUT == $past(lvl_reg))
        else $error("plain output level wrong");
endmodule
bind bifa_top bifa_checker u_chk (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .IN_PINS_IN(IN_PINS_IN), .PULSE_SRC_IN(PULSE_SRC_IN), .OUT_PINS_OUT(OUT_PINS_OUT),
    .HSC_A_OUT(HSC_A_OUT), .HSC_B_OUT(HSC_B_OUT), .HSC_Z_OUT(HSC_Z_OUT),
    .HSC_RST_OUT(HSC_RST_OUT), .ORIGIN_OUT(ORIGIN_OUT));
`default_nettype wire

//--- testbench/bifa_field_model.sv
/*
 * field sensors: all input bits take the commanded levels together, once the
 * vector has differed for more than delay_in cycles, 0 for prompt sensors.
 * assumes level_in is driven by the bench on the rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module bifa_field_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [23:0] level_in,
    input wire logic [3:0] delay_in,
    output logic [23:0] pins_out
);
    logic [3:0] wait_reg;

    // contacts settle only once the response delay has run out
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pins_out <= 24'h000000;
            wait_reg <= 4'h0;
        end else if (pins_out == level_in) begin
            wait_reg <= 4'h0;
        end else if (wait_reg >= delay_in) begin
            pins_out <= level_in;
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- testbench/bifa_tb_top.sv
/*
 * testbench of the i/o function allocator: register access, counter
 * routing table, origin priority, outputs, filter, interrupts, reset.
 * assumes the checker and field model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module bifa_tb_top;
    import bifa_pkg::*;
    typedef struct {logic [15:0] cfg; logic [15:0] hsc; logic [23:0] ins;} bifa_row_t;
    localparam int HMS = 2;
    logic clk, rst, rd, wr, waitr, irq;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [23:0] lvl, pins;
    logic [3:0] dly, ha, hb, hz, hr;
    logic [7:0] outp, orig, quick;
    bifa_pulse_src_t src;
    int fails, checks_done, lim, pin;
    // counter config, expected {a,b,z,reset} outputs, expected filtered inputs
    bifa_row_t rows [6] = '{
        '{16'h0009, 16'h1110, 24'hFFFCF7}, '{16'h00C0, 16'h2202, 24'hFFFF3B},
        '{16'h0B00, 16'h4040, 24'hFFFFED}, '{16'hE000, 16'h8808, 24'hFFE3FF},
        '{16'h0000, 16'h0000, 24'hFFFFFF}, '{16'h8888, 16'hFFF0, 24'hFFE001}};

    bifa_top #(.HALF_MS_CYCLES(HMS)) DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitr), .IN_PINS_IN(pins), .PULSE_SRC_IN(src),
        .OUT_PINS_OUT(outp), .HSC_A_OUT(ha), .HSC_B_OUT(hb), .HSC_Z_OUT(hz),
        .HSC_RST_OUT(hr), .ORIGIN_OUT(orig), .QUICK_OUT(quick), .IRQ_OUT(irq));
    bifa_field_model u_field (.clk_in(clk), .rst_in(rst), .level_in(lvl),
        .delay_in(dly), .pins_out(pins));

    // ========================================
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ========================================
    // compare, verdict and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitr !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) begin
            chk("bus timeout", 32'h0, 32'h1);
            results();
        end
    endtask

    // ========================================
    // main sequence
    initial begin
        {rst, rd, wr, addr, wdata, lvl, dly} = {1'b1, 67'h0};
        src = '0;
        fails = 0;
        checks_done = 0;
        cyc(2);
        rst <= 1'b0;
        bus(0, INCFG_OFS, 32'h0);
        chk("incfg reset", INCFG_RST, q);
        bus(0, 5'h03, 32'h0);
        chk("unmapped read", 32'h0, q);
        bus(1, INCFG_OFS, 32'h0);
        lvl <= 24'hFFFFFF;
        for (int i = 0; i < 6; i++) begin
            bus(1, HSCCFG_OFS, {16'h0, rows[i].cfg});
            cyc(4);
            chk("counter pins", {16'h0, rows[i].hsc}, {16'h0, ha, hb, hz, hr});
            bus(0, INSTATE_OFS, 32'h0);
            chk("instate", {8'h0, rows[i].ins}, q);
        end
        $display("test routing done");
        bus(1, PLSCTL_OFS, 32'hF0);
        bus(1, HSCCFG_OFS, 32'h8);
        bus(1, ORGCFG_OFS, 32'h2);
        cyc(3);
        chk("origin over counter", 32'h0C01, {16'h0, orig, hz, ha});
        bus(1, ORGCFG_OFS, 32'h0);
        bus(1, HSCCFG_OFS, 32'h0);
        bus(1, PLSCTL_OFS, 32'h0);
        bus(1, OUTLVL_OFS, 32'hA5);
        src <= '{a: 4'h0, b: 4'h1};
        cyc(3);
        chk("plain outputs", 32'hA5, {24'h0, outp});
        bus(1, PLSCTL_OFS, 32'h01);
        cyc(3);
        chk("cw ccw outputs", 32'hA6, {24'h0, outp});
        src <= '0;
        bus(1, PLSCTL_OFS, 32'h11);
        cyc(3);
        chk("pulse dir outputs", 32'hA0, {24'h0, outp});
        $display("test outputs done");
        for (int s = 0; s < 8; s++) begin
            lim = (s == 0) ? 0 : (1 << (s - 1)) * HMS;
            bus(1, INCFG_OFS, 32'(s));
            lvl[20] <= 1'b0;
            cyc(lim + 8);
            lvl[20] <= 1'b1;
            cyc(lim);
            bus(0, INSTATE_OFS, 32'h0);
            chk("filter holds", 32'h0, {31'h0, q[20]});
            cyc(lim + 8);
            bus(0, INSTATE_OFS, 32'h0);
            chk("filter passes", 32'h1, {31'h0, q[20]});
        end
        $display("test filter done");
        dly <= 4'h3;
        lvl <= 24'h0;
        bus(1, INCFG_OFS, 32'h0000FF00);
        bus(1, IRQMSK_OFS, 32'hFF);
        cyc(8);
        for (int i = 0; i < 8; i++) begin
            pin = (i < 4) ? i : W1_BASE + i - 4;
            lvl[pin] <= 1'b1;
            cyc(8);
            bus(0, IRQST_OFS, 32'h0);
            chk("irq status", 32'(1 << i), q);
            chk("irq raised", 32'h1, {31'h0, irq});
            bus(1, IRQST_OFS, 32'(1 << i));
            cyc(2);
            chk("irq cleared", 32'h0, {31'h0, irq});
            lvl[pin] <= 1'b0;
            cyc(8);
        end
        bus(1, IRQMSK_OFS, 32'h0);
        bus(1, INCFG_OFS, 32'h00FF0000);
        lvl[13] <= 1'b1;
        cyc(10);
        chk("masked line", 32'h0, {31'h0, irq});
        chk("quick latch", 32'h20, {24'h0, quick});
        bus(0, IRQST_OFS, 32'h0);
        chk("quick status", 32'h2000, q);
        $display("test interrupts done");
        rst <= 1'b1;
        cyc(2);
        chk("reset outputs", 32'h00020000, {14'h0, waitr, outp, quick, irq});
        rst <= 1'b0;
        bus(0, INCFG_OFS, 32'h0);
        chk("incfg after reset", INCFG_RST, q);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
